// [src/telegram_filter_pkg.sv]
// package for the received telegram filter: frame codes, filter codes,
// register map and the shared structs and helper functions.
// assumes one clock domain and an APB master for the register map.
package telegram_filter_pkg;

   // ==========================================================
   // framed command protocol
   localparam logic [7:0]  SYNC_BYTE          = 8'h55;
   localparam logic [7:0]  PKT_COMMON         = 8'h05;
   localparam logic [7:0]  PKT_RESPONSE       = 8'h02;
   localparam logic [7:0]  CMD_FILTER_ADD     = 8'h0b;
   localparam logic [7:0]  CMD_FILTER_ENABLE  = 8'h0e;
   localparam logic [15:0] ADD_DATA_LEN       = 16'h0007;
   localparam logic [15:0] ENABLE_DATA_LEN    = 16'h0003;
   localparam logic [7:0]  RET_OK             = 8'h00;
   localparam logic [7:0]  ERROR_RETURN       = 8'h01;
   localparam logic [7:0]  RET_NOT_SUPPORTED  = 8'h02;
   localparam logic [7:0]  RET_WRONG_PARAM    = 8'h03;
   localparam logic [7:0]  CRC_POLY           = 8'h07;
   localparam logic [3:0]  DATA_BUF_LEN       = 4'h7;
   localparam logic [3:0]  RESP_LAST          = 4'h7;

   // ==========================================================
   // filter codes
   localparam int          MAX_FILTERS        = 30;
   localparam logic [5:0]  MAX_FILTERS_CNT    = 6'h1e;
   localparam logic [7:0]  FTYPE_SENDER       = 8'h00;
   localparam logic [7:0]  FTYPE_TELEGRAM     = 8'h01;
   localparam logic [7:0]  FTYPE_RSSI         = 8'h02;
   localparam logic [7:0]  FTYPE_RECEIVER     = 8'h03;
   localparam int          ACT_TRUE_BIT       = 7;
   localparam int          ACT_REPEAT_BIT     = 6;
   localparam logic [7:0]  OP_OR_ALL          = 8'h00;
   localparam logic [7:0]  OP_AND_ALL         = 8'h01;
   localparam logic [7:0]  OP_HOST_OR_REP_AND = 8'h08;
   localparam logic [7:0]  OP_HOST_AND_REP_OR = 8'h09;
   localparam logic [7:0]  REP_SELECTIVE      = 8'h02;

   // ==========================================================
   // register map (byte addresses)
   localparam logic [11:0] REG_CTRL           = 12'h000;
   localparam logic [11:0] REG_STATUS         = 12'h004;
   localparam logic [11:0] REG_DROPS          = 12'h008;
   localparam int          CTRL_EN_BIT        = 0;
   localparam int          CTRL_OP_LSB        = 8;
   localparam int          CTRL_REP_LSB       = 16;
   localparam int          STAT_CNT_LSB       = 0;
   localparam int          STAT_RET_LSB       = 8;
   localparam int          STAT_BUSY_BIT      = 16;
   localparam logic [7:0]  OP_RST             = 8'h00;
   localparam logic [7:0]  REP_RST            = 8'h00;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic [31:0] sender_id;
      logic [31:0] receiver_id;
      logic [7:0]  telegram_type_field;
      logic [7:0]  rssi_mag;          // level is minus this, in dBm
   } telegram_t;

   typedef struct packed {
      logic [7:0]  ftype;
      logic [31:0] value;
      logic [7:0]  code;
   } filter_entry_t;

   typedef struct packed {
      logic forward;
      logic repeat_tx;
   } decision_t;

   // one byte of crc8, msb first
   function automatic logic [7:0] crc8_step(input logic [7:0] crc,
                                            input logic [7:0] din);
      logic [7:0] c;
      c = crc ^ din;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      return c;
   endfunction

   // combine mode of one action class from the operator byte
   function automatic logic op_is_and(input logic [7:0] op,
                                      input logic       repeat_class);
      case (op)
         OP_AND_ALL:         return 1'b1;
         OP_HOST_OR_REP_AND: return repeat_class;
         OP_HOST_AND_REP_OR: return !repeat_class;
         default:            return 1'b0;
      endcase
   endfunction

endpackage

// [src/crc8_acc.sv]
// running crc8 over a byte stream.
// assumes the caller clears it at the start of each checked span.
module crc8_acc
   import telegram_filter_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // control and data
   input  wire logic       clear,
   input  wire logic       en,
   input  wire logic [7:0] din,
   output logic      [7:0] crc
);

   // ==========================================================
   // accumulator; clear wins so a span can restart on any byte
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         crc <= 8'h00;
      end else if (clear) begin
         crc <= 8'h00;
      end else if (en) begin
         crc <= crc8_step(crc, din);
      end
   end

endmodule

// [src/filter_store.sv]
// storage for the filter table, one write port and one read port.
// assumes read data are wanted one cycle after the address.
module filter_store
   import telegram_filter_pkg::*;
(
   // clock and reset
   input  wire logic                            clk,
   input  wire logic                            sys_rst,
   // write port
   input  wire logic                            wr_en,
   input  wire logic [4:0]                      wr_addr,
   input  wire telegram_filter_pkg::filter_entry_t wr_data,
   // read port
   input  wire logic [4:0]                      rd_addr,
   output telegram_filter_pkg::filter_entry_t   rd_data
);

   filter_entry_t mem [MAX_FILTERS];

   // ==========================================================
   // array has no reset; entries beyond the count are never read
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule

// [src/received_telegram_filter.sv]
// filter engine for received telegrams: command frame parser, filter
// table, sequential evaluation per telegram, and an APB register file.
// assumes command bytes and telegrams are synchronous to clk.

// Summary of operation
// - signal reference is the magnitude of a negative dBm level
// - identifier and type filters test equal or not equal
// - signal filter true-condition: level at or below minus threshold
// - signal filter false-condition: level strictly above minus threshold
// - action is forward only, or forward and repeat
// - repeat part ignored unless selective repeating is set
// - each action class combined by configurable AND or OR
// - at most 30 filters; the next add answers return code 01
// - add frame: sync 55, length 7, type 05, command 0b, checksums
// - type byte: sender, telegram type, signal, receiver
// - four-byte reference follows the type byte
// - codes 00 and 80 forward on false or true, never repeat
// - codes 40 and c0 forward and repeat on false or true
// - with filtering off every telegram is forwarded
// - enable command 0e sets on/off and the operator byte
// - filter repeating needs repeater setting 02
module received_telegram_filter (
   // clock and reset
   input  wire logic                         clk,
   input  wire logic                         sys_rst,
   // apb slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [11:0]                  paddr,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   // command byte stream from the host
   input  wire logic                         cmd_valid,
   input  wire logic [7:0]                   cmd_byte,
   output logic                              cmd_ready,
   // response byte stream to the host
   output logic                              resp_valid,
   output logic      [7:0]                   resp_byte,
   input  wire logic                         resp_ready,
   // received telegrams
   input  wire logic                         tg_valid,
   input  wire telegram_filter_pkg::telegram_t tg_data,
   output logic                              tg_ready,
   // filter decision
   output logic                              dec_valid,
   output telegram_filter_pkg::decision_t    dec_data
);
   import telegram_filter_pkg::*;

   typedef enum logic [2:0] {
      ST_SYNC, ST_HDR, ST_HCRC, ST_DATA, ST_DCRC, ST_EXEC, ST_RESP
   } parse_state_t;

   typedef enum logic [1:0] {
      EV_IDLE, EV_READ, EV_CMP, EV_DONE
   } eval_state_t;

   localparam logic [7:0] RESP_HCRC =
      crc8_step(crc8_step(crc8_step(crc8_step(8'h00, 8'h00), 8'h01),
                          8'h00), PKT_RESPONSE);

   parse_state_t   pst_r;
   eval_state_t    est_r;
   logic [1:0]     hdr_idx_r;
   logic [15:0]    data_len_r;
   logic [7:0]     opt_len_r;
   logic [7:0]     pkt_type_r;
   logic [16:0]    data_left_r;
   logic [3:0]     data_idx_r;
   logic [7:0]     data_buf_r [DATA_BUF_LEN];
   logic [3:0]     resp_idx_r;
   logic [7:0]     ret_r;
   logic [7:0]     ret_nxt;
   logic           respond_nxt;
   logic           store_nxt;
   logic           en_set_nxt;
   logic [5:0]     filter_cnt_r;
   logic           filt_en_r;
   logic [7:0]     filt_op_r;
   logic [7:0]     rep_set_r;
   logic [15:0]    drops_r;
   logic           byte_take;
   logic           crc_clear;
   logic [7:0]     crc_now;
   filter_entry_t  new_entry;
   filter_entry_t  rd_entry;
   telegram_t      tg_r;
   logic [4:0]     ev_idx_r;
   logic [5:0]     ev_cnt_r;
   logic           host_all_r, host_any_r, host_seen_r;
   logic           rep_all_r, rep_any_r, rep_seen_r;
   logic           cond, passed;
   logic           host_res, rep_res;
   logic           apb_wr;

   // ==========================================================
   // running checksum over header and over payload
   assign byte_take = cmd_valid && cmd_ready;
   assign crc_clear = (pst_r == ST_SYNC) || (pst_r == ST_HCRC);

   crc8_acc u_crc (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clear   (crc_clear),
      .en      (byte_take),
      .din     (cmd_byte),
      .crc     (crc_now)
   );

   // ==========================================================
   // frame parser
   assign cmd_ready = (pst_r != ST_EXEC) && (pst_r != ST_RESP);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pst_r       <= ST_SYNC;
         hdr_idx_r   <= 2'd0;
         data_len_r  <= 16'h0000;
         opt_len_r   <= 8'h00;
         pkt_type_r  <= 8'h00;
         data_left_r <= 17'h00000;
         data_idx_r  <= 4'h0;
         drops_r     <= 16'h0000;
      end else begin
         case (pst_r)
            ST_SYNC: begin
               hdr_idx_r <= 2'd0;
               if (byte_take && cmd_byte == SYNC_BYTE) begin
                  pst_r <= ST_HDR;
               end
            end
            ST_HDR: if (byte_take) begin
               hdr_idx_r <= hdr_idx_r + 2'd1;
               case (hdr_idx_r)
                  2'd0:    data_len_r[15:8] <= cmd_byte;
                  2'd1:    data_len_r[7:0]  <= cmd_byte;
                  2'd2:    opt_len_r        <= cmd_byte;
                  default: begin
                     pkt_type_r <= cmd_byte;
                     pst_r      <= ST_HCRC;
                  end
               endcase
            end
            ST_HCRC: if (byte_take) begin
               data_idx_r  <= 4'h0;
               data_left_r <= {1'b0, data_len_r} + {9'h000, opt_len_r};
               if (cmd_byte != crc_now) begin
                  drops_r <= drops_r + 16'h0001;
                  pst_r   <= ST_SYNC;
               end else if (data_len_r == 16'h0000 && opt_len_r == 8'h00)
               begin
                  pst_r <= ST_DCRC;
               end else begin
                  pst_r <= ST_DATA;
               end
            end
            ST_DATA: if (byte_take) begin
               if (data_idx_r != DATA_BUF_LEN) begin
                  data_idx_r <= data_idx_r + 4'h1;
               end
               data_left_r <= data_left_r - 17'h00001;
               if (data_left_r == 17'h00001) begin
                  pst_r <= ST_DCRC;
               end
            end
            ST_DCRC: if (byte_take) begin
               if (cmd_byte != crc_now) begin
                  drops_r <= drops_r + 16'h0001;
                  pst_r   <= ST_SYNC;
               end else begin
                  pst_r <= ST_EXEC;
               end
            end
            ST_EXEC: pst_r <= respond_nxt ? ST_RESP : ST_SYNC;
            ST_RESP: if (resp_ready && resp_idx_r == RESP_LAST) begin
               pst_r <= ST_SYNC;
            end
            default: pst_r <= ST_SYNC;
         endcase
      end
   end

   // payload bytes beyond the buffer are still checked, not stored
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < DATA_BUF_LEN; i++) begin
            data_buf_r[i] <= 8'h00;
         end
      end else if (pst_r == ST_DATA && byte_take &&
                   data_idx_r != DATA_BUF_LEN) begin
         data_buf_r[data_idx_r[2:0]] <= cmd_byte;
      end
   end

   // ==========================================================
   // command execution
   assign new_entry = '{ftype: data_buf_r[1],
                        value: {data_buf_r[2], data_buf_r[3],
                                data_buf_r[4], data_buf_r[5]},
                        code:  data_buf_r[6]};

   always_comb begin
      respond_nxt = (pkt_type_r == PKT_COMMON);
      ret_nxt     = RET_NOT_SUPPORTED;
      store_nxt   = 1'b0;
      en_set_nxt  = 1'b0;
      if (data_buf_r[0] == CMD_FILTER_ADD) begin
         if (data_len_r != ADD_DATA_LEN ||
             new_entry.ftype > FTYPE_RECEIVER ||
             new_entry.code[5:0] != 6'h00) begin
            ret_nxt = RET_WRONG_PARAM;
         end else if (filter_cnt_r == MAX_FILTERS_CNT) begin
            ret_nxt = ERROR_RETURN;
         end else begin
            ret_nxt   = RET_OK;
            store_nxt = 1'b1;
         end
      end else if (data_buf_r[0] == CMD_FILTER_ENABLE) begin
         if (data_len_r != ENABLE_DATA_LEN) begin
            ret_nxt = RET_WRONG_PARAM;
         end else begin
            ret_nxt    = RET_OK;
            en_set_nxt = 1'b1;
         end
      end
   end

   filter_store u_store (
      .clk     (clk),
      .sys_rst (sys_rst),
      .wr_en   (pst_r == ST_EXEC && respond_nxt && store_nxt),
      .wr_addr (filter_cnt_r[4:0]),
      .wr_data (new_entry),
      .rd_addr (ev_idx_r),
      .rd_data (rd_entry)
   );

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         filter_cnt_r <= 6'd0;
         ret_r        <= RET_OK;
      end else if (pst_r == ST_EXEC && respond_nxt) begin
         ret_r <= ret_nxt;
         if (store_nxt) begin
            filter_cnt_r <= filter_cnt_r + 6'd1;
         end
      end
   end

   // ==========================================================
   // response frame: sync, length 1, no option, response, crcs
   function automatic logic [7:0] resp_at(input logic [3:0] idx,
                                          input logic [7:0] ret);
      case (idx)
         4'h0:    return SYNC_BYTE;
         4'h2:    return 8'h01;
         4'h4:    return PKT_RESPONSE;
         4'h5:    return RESP_HCRC;
         4'h6:    return ret;
         4'h7:    return crc8_step(8'h00, ret);
         default: return 8'h00;
      endcase
   endfunction

   assign resp_valid = (pst_r == ST_RESP);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         resp_idx_r <= 4'h0;
         resp_byte  <= 8'h00;
      end else if (pst_r == ST_EXEC) begin
         resp_idx_r <= 4'h0;
         resp_byte  <= resp_at(4'h0, ret_nxt);
      end else if (resp_valid && resp_ready) begin
         resp_idx_r <= resp_idx_r + 4'h1;
         resp_byte  <= resp_at(resp_idx_r + 4'h1, ret_r);
      end
   end

   // ==========================================================
   // apb register file; always ready, no wait states
   assign pready = 1'b1;
   assign apb_wr = psel && penable && pwrite;

   function automatic logic addr_ok(input logic [11:0] a);
      return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_DROPS);
   endfunction

   assign pslverr = psel && penable && !addr_ok(paddr);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         filt_en_r <= 1'b0;
         filt_op_r <= OP_RST;
         rep_set_r <= REP_RST;
      end else begin
         if (apb_wr && paddr == REG_CTRL) begin
            filt_en_r <= pwdata[CTRL_EN_BIT];
            filt_op_r <= pwdata[CTRL_OP_LSB +: 8];
            rep_set_r <= pwdata[CTRL_REP_LSB +: 8];
         end
         if (pst_r == ST_EXEC && respond_nxt && en_set_nxt) begin
            filt_en_r <= data_buf_r[1][0];
            filt_op_r <= data_buf_r[2];
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         case (paddr)
            REG_CTRL:   prdata <= {8'h00, rep_set_r, filt_op_r,
                                   7'h00, filt_en_r};
            REG_STATUS: prdata <= {15'h0000, (est_r != EV_IDLE),
                                   ret_r, 2'b00, filter_cnt_r};
            REG_DROPS:  prdata <= {16'h0000, drops_r};
            default:    prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // per-filter condition and action match
   always_comb begin
      case (rd_entry.ftype)
         FTYPE_SENDER:   cond = tg_r.sender_id == rd_entry.value;
         FTYPE_RECEIVER: cond = tg_r.receiver_id == rd_entry.value;
         FTYPE_TELEGRAM: cond =
            tg_r.telegram_type_field == rd_entry.value[7:0];
         // -rx <= -ref is rx >= ref in magnitudes
         FTYPE_RSSI:     cond = tg_r.rssi_mag >= rd_entry.value[7:0];
         default:        cond = 1'b0;
      endcase
      // code bit 7 clear: filter passes when the condition is false
      passed = (cond == rd_entry.code[ACT_TRUE_BIT]);
   end

   // ==========================================================
   // sequential evaluation, two cycles per stored filter
   assign tg_ready = (est_r == EV_IDLE);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         est_r       <= EV_IDLE;
         ev_idx_r    <= 5'd0;
         ev_cnt_r    <= 6'd0;
         tg_r        <= '0;
         host_all_r  <= 1'b1;
         host_any_r  <= 1'b0;
         host_seen_r <= 1'b0;
         rep_all_r   <= 1'b1;
         rep_any_r   <= 1'b0;
         rep_seen_r  <= 1'b0;
      end else begin
         case (est_r)
            EV_IDLE: if (tg_valid) begin
               tg_r        <= tg_data;
               ev_idx_r    <= 5'd0;
               ev_cnt_r    <= filter_cnt_r;  // adds mid-run not seen
               host_all_r  <= 1'b1;
               host_any_r  <= 1'b0;
               host_seen_r <= 1'b0;
               rep_all_r   <= 1'b1;
               rep_any_r   <= 1'b0;
               rep_seen_r  <= 1'b0;
               est_r <= (filter_cnt_r == 6'd0) ? EV_DONE : EV_READ;
            end
            EV_READ: est_r <= EV_CMP;
            EV_CMP: begin
               host_seen_r <= 1'b1;
               host_all_r  <= host_all_r && passed;
               host_any_r  <= host_any_r || passed;
               if (rd_entry.code[ACT_REPEAT_BIT]) begin
                  rep_seen_r <= 1'b1;
                  rep_all_r  <= rep_all_r && passed;
                  rep_any_r  <= rep_any_r || passed;
               end
               if ({1'b0, ev_idx_r} + 6'd1 == ev_cnt_r) begin
                  est_r <= EV_DONE;
               end else begin
                  ev_idx_r <= ev_idx_r + 5'd1;
                  est_r    <= EV_READ;
               end
            end
            EV_DONE: est_r <= EV_IDLE;
            default: est_r <= EV_IDLE;
         endcase
      end
   end

   // ==========================================================
   // decision
   assign host_res = op_is_and(filt_op_r, 1'b0) ? host_all_r
                                                : host_any_r;
   assign rep_res  = op_is_and(filt_op_r, 1'b1) ? rep_all_r
                                                : rep_any_r;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dec_valid <= 1'b0;
         dec_data  <= '0;
      end else begin
         dec_valid <= (est_r == EV_DONE);
         if (est_r == EV_DONE) begin
            // an empty table forwards; filtering off forwards all
            dec_data.forward <= !filt_en_r || !host_seen_r ||
                                host_res;
            dec_data.repeat_tx <= (rep_set_r == REP_SELECTIVE) &&
                                  rep_seen_r && rep_res;
         end
      end
   end

   // host-side duty: 8-bit references arrive zero-extended

endmodule

// [sim/rtf_props.sv]
// port checker for the telegram filter, bound into the design
// assumes one clock and the hand-over handshake timing
module rtf_props (
   input wire logic        clk, sys_rst, psel, penable, pready, pslverr,
   input wire logic        cmd_ready, resp_valid, resp_ready,
   input wire logic        tg_valid, tg_ready, dec_valid,
   input wire logic [11:0] paddr,
   input wire logic [7:0]  resp_byte
);
   timeunit 1ns / 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_apb_ready: assert property (psel && penable |-> pready)
      else $error("apb stall");
   a_apb_err: assert property (psel && penable && paddr > 12'h008
      |-> pslverr) else $error("unmapped not flagged");
   a_dec_pulse: assert property (dec_valid |=> !dec_valid)
      else $error("long decision strobe");
   a_dec_bound: assert property (tg_valid && tg_ready
      |-> ##[2:62] dec_valid) else $error("decision late");
   a_eval_busy: assert property (tg_valid && tg_ready |=> !tg_ready)
      else $error("taken while busy");
   a_resp_hold: assert property (resp_valid && !resp_ready
      |=> resp_valid && $stable(resp_byte)) else $error("byte lost");
   a_resp_sync: assert property ($rose(resp_valid)
      |-> resp_byte == 8'h55) else $error("no sync first");
   a_cmd_stall: assert property (resp_valid |-> !cmd_ready)
      else $error("command taken while answering");
endmodule

// [sim/host_model.sv]
// host side of the command stream: sends frames, takes responses
// assumes handshakes are sampled on the rising clk edge
module host_model (
   input  wire logic       clk,
   output logic            cmd_valid = 1'b0,
   output logic      [7:0] cmd_byte = 8'h00,
   input  wire logic       cmd_ready,
   input  wire logic       resp_valid,
   input  wire logic [7:0] resp_byte,
   output logic            resp_ready = 1'b0
);
   timeunit 1ns / 1ps;
   function automatic logic [7:0] crc(logic [7:0] c, logic [7:0] d);
      c = c ^ d;
      for (int i = 0; i < 8; i++)
         c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
      return c;
   endfunction
   // reader stalls every other cycle to stress the response hold
   always @(posedge clk)
      resp_ready <= ~resp_ready;
   task automatic put(logic [7:0] b);
      cmd_valid <= 1'b1;
      cmd_byte <= b;
      @(posedge clk iff cmd_ready);
   endtask
   // bad flips the payload checksum so the frame must be dropped
   task automatic frame(logic [7:0] d[$], logic bad, output logic [7:0] r);
      logic [7:0] h[$] = {8'h00, 8'(d.size()), 8'h00, 8'h05};
      logic [7:0] hc = 8'h00;
      logic [7:0] dc = 8'h00;
      foreach (h[i]) hc = crc(hc, h[i]);
      foreach (d[i]) dc = crc(dc, d[i]);
      r = 8'hff;
      @(posedge clk);
      put(8'h55);
      foreach (h[i]) put(h[i]);
      put(hc);
      foreach (d[i]) put(d[i]);
      put(dc ^ {7'h00, bad});
      cmd_valid <= 1'b0;
      cmd_byte <= ~cmd_byte;
      for (int k = 0; k < 8 && !bad; k++) begin
         @(posedge clk iff (resp_valid && resp_ready));
         if (k == 6) r = resp_byte;
         if (k == 7 && resp_byte !== crc(8'h00, r)) r = 8'hee;
      end
   endtask
endmodule

// [sim/tb_received_telegram_filter.sv]
// self-checking bench for the telegram filter
// assumes host_model on the command stream, checker bound below
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
   n_mismatch++; $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_received_telegram_filter;
   timeunit 1ns / 1ps;
   import telegram_filter_pkg::*;
   logic        clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, tg_valid = 1'b0, pready, pslverr, err;
   logic        cmd_valid, cmd_ready, resp_valid, resp_ready;
   logic        tg_ready, dec_valid;
   logic [7:0]  cmd_byte, resp_byte, r8;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   telegram_t   tg_data = '0;
   decision_t   dec_data;
   int          n_mismatch = 0, samples_checked = 0, cyc = 0;
   received_telegram_filter i_received_telegram_filter (.*);
   host_model i_host_model (.*);
   always #20 clk = ~clk;
   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 9000) begin
         n_mismatch++;
         final_report();
      end
   end
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk iff pready);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic add(logic [7:0] t, logic [31:0] v, logic [7:0] c, e);
      i_host_model.frame({8'h0b, t, v[31:24], v[23:16], v[15:8], v[7:0],
         c}, 1'b0, r8);
      `CHK("return code", e, r8)
   endtask
   task automatic tg(logic [31:0] s, logic [7:0] m, logic f, p);
      @(posedge clk);
      tg_valid <= 1'b1;
      tg_data <= '{s, 32'h0000_0c0d, 8'hf6, m};
      @(posedge clk iff tg_ready);
      tg_valid <= 1'b0;
      @(posedge clk iff dec_valid);
      `CHK("forward", f, dec_data.forward)
      `CHK("repeat", p, dec_data.repeat_tx)
   endtask
   task automatic t_idle;
      apb(1'b0, 12'h000, 32'h0);
      `CHK("ctrl", 32'h0, rd)
      apb(1'b0, 12'h00c, 32'h0);
      `CHK("slverr", 1'b1, err)
      tg(32'h0000_00b0, 8'd40, 1'b1, 1'b0);
      $display("idle done");
   endtask
   task automatic t_eval;
      add(8'h00, 32'h0000_00a0, 8'h80, 8'h00);
      add(8'h02, 32'd80, 8'hc0, 8'h00);
      add(8'h03, 32'h0000_0c0d, 8'h40, 8'h00);
      apb(1'b1, 12'h000, 32'h0002_0001);
      tg(32'h0000_00a0, 8'd80, 1'b1, 1'b1);
      tg(32'h0000_00b0, 8'd79, 1'b0, 1'b0);
      tg(32'h0000_00b0, 8'd81, 1'b1, 1'b1);
      i_host_model.frame({8'h0e, 8'h01, 8'h08}, 1'b0, r8);
      `CHK("enable", 8'h00, r8)
      apb(1'b0, 12'h000, 32'h0);
      `CHK("ctrl op", 32'h0002_0801, rd)
      tg(32'h0000_00b0, 8'd81, 1'b1, 1'b0);
      apb(1'b1, 12'h000, 32'h0002_0901);
      tg(32'h0000_00b0, 8'd81, 1'b0, 1'b1);
      apb(1'b1, 12'h000, 32'h0002_0101);
      tg(32'h0000_00a0, 8'd81, 1'b0, 1'b0);
      apb(1'b1, 12'h000, 32'h0000_0001);
      tg(32'h0000_00b0, 8'd81, 1'b1, 1'b0);
      apb(1'b1, 12'h000, 32'h0002_0000);
      tg(32'h0000_00b0, 8'd79, 1'b1, 1'b0);
      $display("evaluation done");
   endtask
   task automatic t_full;
      i_host_model.frame({8'h0b, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h80},
         1'b1, r8);
      apb(1'b0, 12'h004, 32'h0);
      `CHK("count", 6'h03, rd[5:0])
      apb(1'b0, 12'h008, 32'h0);
      `CHK("drops", 16'h0001, rd[15:0])
      add(8'h04, 32'h0, 8'h80, 8'h03);
      for (int i = 3; i < 30; i++)
         add(8'h00, 32'(i), 8'h80, 8'h00);
      add(8'h00, 32'h0000_0077, 8'h80, 8'h01);
      apb(1'b0, 12'h004, 32'h0);
      `CHK("status", 16'h011e, rd[15:0])
      $display("table done");
   endtask
   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      t_idle();
      t_eval();
      t_full();
      final_report();
   end
endmodule
bind received_telegram_filter rtf_props i_rtf_props (.*);
